// [logic/nfh_host.sv]
/*
 nfh_host: apb-driven controller that steps a nand flash through its strobe pins.
 assumes the flash pins are wired directly; io_port and ready_busy_n come from
 another timing domain and are synchronised here; ready_busy_n has a pull-up.
*/
`timescale 1ns/100ps
// How it works
// [R1] command byte written with command latch high
// [R2] address byte written with address latch high
// [R3] data byte written with both latches low
// [R4] deselect during read puts flash in standby
// [R5] flash ignores deselect while busy programming
// [R6] select held low through read busy
// [R7] each read strobe fall yields next byte
// [R8] write guard low inhibits program and erase
// [R9] ready_busy low during program erase read
// [R10] page 528 bytes, 16 pages, 1024 blocks
// [R11] address sent as three bytes, low first
// [R12] third address byte top two lines low
// [R13] bit 8 chosen by read command only
// [R14] page bits 9-12, block bits 13-22
// [R15] write strobes with read high, reads likewise
// [R16] command codes as listed
// [R17] read mode persists across page reads
// [R18] flash drives port only while read low
// [R19] select high 100 ns ends sequential read
// [R20] at most five programs per page; the host counts only the last programmed page
// [R21] only status or reset while busy
// [R22] after serial input only program or reset
// [R23] status byte after status command
// [R24] wait for ready before other commands
module nfh_host (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             select_n,
   output logic             command_latch_strobe,
   output logic             address_latch_strobe,
   output logic             write_strobe_n,
   output logic             read_strobe_n,
   output logic             write_guard_n,
   output logic      [7:0]  io_port_o,
   output logic             io_port_oe,
   input  wire logic [7:0]  io_port_i,
   input  wire logic        ready_busy_n
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [7:0] io_meta, io_sync;
   logic       rb_meta, rb_sync;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_meta <= 8'h00;
         io_sync <= 8'h00;
         rb_meta <= 1'b1;
         rb_sync <= 1'b1;
      end else begin
         io_meta <= io_port_i;
         io_sync <= io_meta;
         rb_meta <= ready_busy_n;
         rb_sync <= rb_meta;
      end
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   nfh_pkg::nfh_state_e state, next_state;
   logic [1:0]  op, acyc;
   logic [7:0]  byte_out, byte_in;
   logic        end_seq, guard, done_flag, cmd_err, cap_due;
   logic [7:0]  last_cmd;
   logic [2:0]  cnt, prog_cnt;
   logic [13:0] page_cur, page_prog;
   wire access   = psel && penable;
   wire idle     = (state == nfh_pkg::NFH_IDLE);
   wire wr_ctrl  = access && pwrite && (paddr == nfh_pkg::REG_CTRL);
   wire wr_pins  = access && pwrite && (paddr == nfh_pkg::REG_PINS);
   wire mapped   = (paddr == nfh_pkg::REG_CTRL) || (paddr == nfh_pkg::REG_WDATA) ||
                   (paddr == nfh_pkg::REG_RDATA) || (paddr == nfh_pkg::REG_STATUS) ||
                   (paddr == nfh_pkg::REG_PINS);
   wire start    = wr_ctrl && idle;
   wire [1:0] new_op = pwdata[nfh_pkg::CTRL_OP_LSB +: 2];
   // while busy only status or reset may be sent; others are refused
   wire busy_bad = (new_op == nfh_pkg::OP_CMD) && !rb_sync &&          // [R21] [R24]
                   (pwdata[15:8] != nfh_pkg::CMD_STATUS) &&
                   (pwdata[15:8] != nfh_pkg::CMD_RESET);
   // after serial input only program or reset keeps the operation alive
   wire seq_bad  = (new_op == nfh_pkg::OP_CMD) &&                      // [R22]
                   (last_cmd == nfh_pkg::CMD_SERIAL_IN) &&
                   (pwdata[15:8] != nfh_pkg::CMD_PROGRAM) &&
                   (pwdata[15:8] != nfh_pkg::CMD_RESET);
   // only the last programmed page is remembered; interleaved pages escape the limit
   wire same_page = (page_cur == page_prog) && (prog_cnt != 3'h0);
   wire prog_bad  = (new_op == nfh_pkg::OP_CMD) && same_page &&                 // [R20]
                    (pwdata[15:8] == nfh_pkg::CMD_PROGRAM) &&
                    (prog_cnt >= 3'(nfh_pkg::MAX_PROGRAMS));
   wire refuse   = busy_bad || seq_bad || prog_bad;
   wire take_cmd  = start && !refuse && (new_op == nfh_pkg::OP_CMD);
   wire take_addr = start && !refuse && (new_op == nfh_pkg::OP_ADDR);
   // third address cycle keeps its top two lines low
   wire [7:0] out_byte = (take_addr && acyc == 2'h2) ? {2'b00, pwdata[13:8]} :   // [R12]
                         pwdata[15:8];
   // erase sends page bytes only, so its address starts at the second cycle;
   // an erase clears the count whatever block it names
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acyc      <= 2'h0;
         page_cur  <= 14'h0000;
         page_prog <= 14'h0000;
         prog_cnt  <= 3'h0;
      end else begin
         if (take_cmd)
            acyc <= (pwdata[15:8] == nfh_pkg::CMD_ERASE_SET) ? 2'h1 : 2'h0;   // [R11]
         else if (take_addr)
            acyc <= (acyc == 2'h2) ? 2'h0 : acyc + 2'h1;
         if (take_addr && acyc == 2'h1)
            page_cur[7:0] <= pwdata[15:8];
         if (take_addr && acyc == 2'h2)
            page_cur[13:8] <= pwdata[13:8];
         if (take_cmd && pwdata[15:8] == nfh_pkg::CMD_PROGRAM) begin         // [R20]
            page_prog <= page_cur;
            prog_cnt  <= same_page ? prog_cnt + 3'h1 : 3'h1;
         end else if (take_cmd && pwdata[15:8] == nfh_pkg::CMD_ERASE_GO)
            prog_cnt <= 3'h0;
      end
   end
   wire [31:0] rd_mux =
      (paddr == nfh_pkg::REG_RDATA)  ? {24'h000000, byte_in} :
      (paddr == nfh_pkg::REG_STATUS) ? {26'h0, cmd_err, done_flag, rb_sync, 1'b0, idle,
                                        !guard} :
      (paddr == nfh_pkg::REG_PINS)   ? {31'h0, guard} :
      (paddr == nfh_pkg::REG_CTRL)   ? {16'h0, last_cmd, 5'h0, end_seq, op} : 32'h0;

   // ------------------------------------------------------------
   // strobe sequencer
   // ------------------------------------------------------------
   wire is_write = (op != nfh_pkg::OP_READ);
   wire cnt_zero = (cnt == 3'h0);
   always_comb begin
      next_state = state;
      unique case (state)
         nfh_pkg::NFH_IDLE:  if (start && !refuse) next_state = nfh_pkg::NFH_SETUP;
         nfh_pkg::NFH_SETUP: next_state = is_write ? nfh_pkg::NFH_WLOW : nfh_pkg::NFH_RLOW;
         nfh_pkg::NFH_WLOW:  next_state = nfh_pkg::NFH_WHIGH;
         nfh_pkg::NFH_WHIGH: next_state = nfh_pkg::NFH_IDLE;
         nfh_pkg::NFH_RLOW:  next_state = nfh_pkg::NFH_RHIGH;
         nfh_pkg::NFH_RHIGH: next_state = end_seq ? nfh_pkg::NFH_DESEL : nfh_pkg::NFH_IDLE;
         nfh_pkg::NFH_DESEL: if (cnt_zero) next_state = nfh_pkg::NFH_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= nfh_pkg::NFH_IDLE;
         op       <= nfh_pkg::OP_CMD;
         byte_out <= 8'h00;
         byte_in  <= 8'h00;
         end_seq  <= 1'b0;
         last_cmd <= nfh_pkg::CMD_RESET;
         cnt      <= 3'h0;
         cap_due  <= 1'b0;
      end else begin
         state <= next_state;
         if (start && !refuse) begin
            op       <= new_op;
            byte_out <= out_byte;
            end_seq  <= pwdata[nfh_pkg::CTRL_END_BIT];
            if (new_op == nfh_pkg::OP_CMD)
               last_cmd <= pwdata[15:8];                                // [R16] [R17]
         end
         // the pin byte reaches io_sync one cycle after the strobe rises
         cap_due <= (state == nfh_pkg::NFH_RHIGH);
         if (cap_due)
            byte_in <= io_sync;                                          // [R7] [R18] [R23]
         if (state == nfh_pkg::NFH_RHIGH)
            cnt <= 3'(nfh_pkg::SELECT_HIGH_CYC);
         else if (!cnt_zero)
            cnt <= cnt - 3'h1;
      end
   end

   // ------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------
   wire op_done = (state == nfh_pkg::NFH_WHIGH) || (state == nfh_pkg::NFH_RHIGH);
   // clear at the edge that copies the bits out, so no event slips between
   wire clr_st  = psel && !penable && !pwrite && (paddr == nfh_pkg::REG_STATUS);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_flag <= 1'b0;
         cmd_err   <= 1'b0;
         guard     <= nfh_pkg::RST_PINS[nfh_pkg::PINS_GUARD_BIT];
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h0;
      end else begin
         // set wins over read-clear
         done_flag <= op_done | (done_flag & !clr_st);
         cmd_err   <= (start & refuse) | (cmd_err & !clr_st);
         if (wr_pins)
            guard <= pwdata[nfh_pkg::PINS_GUARD_BIT];                    // [R8]
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
      end
   end

   // ------------------------------------------------------------
   // pin drivers
   // ------------------------------------------------------------
   wire in_xfer = !idle;
   wire wphase  = (state == nfh_pkg::NFH_SETUP) || (state == nfh_pkg::NFH_WLOW) ||
                  (state == nfh_pkg::NFH_WHIGH);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select_n             <= 1'b1;
         command_latch_strobe <= 1'b0;
         address_latch_strobe <= 1'b0;
         write_strobe_n       <= 1'b1;
         read_strobe_n        <= 1'b1;
         write_guard_n        <= 1'b0;
         io_port_o            <= 8'h00;
         io_port_oe           <= 1'b0;
      end else begin
         // select stays low between reads unless a deselect is asked   [R6] [R19]
         select_n <= (next_state == nfh_pkg::NFH_DESEL) ? 1'b1 :
                     (next_state != nfh_pkg::NFH_IDLE) ? 1'b0 : select_n & !in_xfer;
         command_latch_strobe <= is_write && (op == nfh_pkg::OP_CMD) &&        // [R1]
                                 (next_state inside {nfh_pkg::NFH_SETUP, nfh_pkg::NFH_WLOW,
                                                     nfh_pkg::NFH_WHIGH});
         address_latch_strobe <= (op == nfh_pkg::OP_ADDR) &&                     // [R2] [R11]
                                 (next_state inside {nfh_pkg::NFH_SETUP, nfh_pkg::NFH_WLOW,
                                                     nfh_pkg::NFH_WHIGH});
         write_strobe_n <= !(next_state == nfh_pkg::NFH_WLOW);                  // [R3] [R15]
         read_strobe_n  <= !(next_state == nfh_pkg::NFH_RLOW);                  // [R15]
         write_guard_n  <= guard;                                               // [R8]
         io_port_o      <= byte_out;                                            // [R12]
         io_port_oe     <= is_write && wphase && (next_state != nfh_pkg::NFH_IDLE);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_wpulse;
      !write_strobe_n ##1 write_strobe_n;
   endsequence
   property p_cmd_latch;
      @(posedge pclk) disable iff (!presetn)
      (command_latch_strobe && !write_strobe_n) |-> ##1 (command_latch_strobe && write_strobe_n);
   endproperty
   a_cmd_latch: assert property (p_cmd_latch) else $error("cmd latch dropped early"); // [R1]
   property p_addr_latch;
      @(posedge pclk) disable iff (!presetn)
      (address_latch_strobe && !write_strobe_n) |-> io_port_oe ##1 address_latch_strobe;
   endproperty
   a_addr_latch: assert property (p_addr_latch) else $error("addr latch bad"); // [R2]
   property p_write_rd_high;
      @(posedge pclk) disable iff (!presetn)
      s_wpulse |-> (read_strobe_n && !select_n && $past(read_strobe_n));
   endproperty
   a_write_rd_high: assert property (p_write_rd_high) else $error("write with read low"); // [R15]
   property p_no_both;
      @(posedge pclk) disable iff (!presetn)
      !(command_latch_strobe && address_latch_strobe);
   endproperty
   a_no_both: assert property (p_no_both) else $error("both latches high"); // [R3]
   property p_read_bus;
      @(posedge pclk) disable iff (!presetn)
      !read_strobe_n |-> (!io_port_oe && !command_latch_strobe && !address_latch_strobe
                          && write_strobe_n && !select_n);
   endproperty
   a_read_bus: assert property (p_read_bus) else $error("read strobe with bus driven"); // [R18]
   property p_desel;
      @(posedge pclk) disable iff (!presetn)
      $rose(select_n) && $past(state) == nfh_pkg::NFH_RHIGH |-> select_n [*2];
   endproperty
   a_desel: assert property (p_desel) else $error("deselect too short"); // [R19]
   property p_guard;
      @(posedge pclk) disable iff (!presetn)
      wr_pins |-> ##2 (write_guard_n == $past(pwdata[0], 2));
   endproperty
   a_guard: assert property (p_guard) else $error("guard pin not following register"); // [R8]
   property p_busy_refuse;
      @(posedge pclk) disable iff (!presetn)
      (start && busy_bad) |-> ##1 (idle && cmd_err) ##1 write_strobe_n;
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("busy command sent"); // [R21]
endmodule

// [logic/nfh_pkg.sv]
/*
 nfh_pkg: constants, types and register map for the nand flash host controller.
 assumes a single 20 MHz pclk domain and an apb master reaching the controller.
*/
package nfh_pkg;
   // ------------------------------------------------------------
   // clock, pin timing and array limits
   // ------------------------------------------------------------
   localparam int CLK_NS            = 50;
   localparam int SELECT_HIGH_NS    = 100;
   localparam int SELECT_HIGH_CYC   = (SELECT_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAIT_BUSY_NS      = 200;
   localparam int WAIT_BUSY_CYC     = (WAIT_BUSY_NS + CLK_NS - 1) / CLK_NS;
   localparam int PAGE_BYTES        = 528;
   localparam int PAGE_MAIN         = 512;
   localparam int PAGE_SPARE        = 16;
   localparam int BLOCK_PAGES       = 16;
   localparam int ARRAY_BLOCKS      = 1024;
   localparam int MAX_PROGRAMS      = 5;
   // ------------------------------------------------------------
   // command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
   localparam logic [7:0] CMD_READ_A    = 8'h00;
   localparam logic [7:0] CMD_READ_B    = 8'h01;
   localparam logic [7:0] CMD_READ_C    = 8'h50;
   localparam logic [7:0] CMD_RESET     = 8'hFF;
   localparam logic [7:0] CMD_PROGRAM   = 8'h10;
   localparam logic [7:0] CMD_ERASE_SET = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
   localparam logic [7:0] CMD_STATUS    = 8'h70;
   localparam logic [7:0] CMD_IDENT     = 8'h90;
   // ------------------------------------------------------------
   // apb register map
   // ------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_WDATA  = 8'h04;
   localparam logic [7:0] REG_RDATA  = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_PINS   = 8'h10;
   // ctrl write: [1:0] op, [2] end, [15:8] of wdata is the byte
   localparam logic [1:0] OP_CMD  = 2'h0;
   localparam logic [1:0] OP_ADDR = 2'h1;
   localparam logic [1:0] OP_DATA = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_END_BIT = 2;
   localparam int PINS_GUARD_BIT = 0;
   localparam logic [31:0] RST_PINS = 32'h0000_0000;

   typedef enum logic [2:0] {
      NFH_IDLE, NFH_SETUP, NFH_WLOW, NFH_WHIGH, NFH_RLOW, NFH_RHIGH, NFH_DESEL
   } nfh_state_e;

   typedef struct packed {
      logic       select_n;
      logic       cmd_latch;
      logic       addr_latch;
      logic       write_n;
      logic       read_n;
      logic       guard_n;
   } nfh_strobe_s;
endpackage

// [verification/nfh_flash_model.sv]
/*
 nfh_flash_model: behavioural nand flash that answers the host's strobes.
 assumes the bench resolves the shared port and the pulled-up ready line.
*/
`timescale 1ns/100ps
module nfh_flash_model #(
   parameter int         PROG_NS  = 4000,
   parameter int         READ_NS  = 1000,
   parameter logic [7:0] ID_MAKER = 8'h3C, // arbitrary value
   parameter logic [7:0] ID_DEV   = 8'hC3  // arbitrary value
) (
   input  wire logic       select_n,
   input  wire logic       command_latch_strobe,
   input  wire logic       address_latch_strobe,
   input  wire logic       write_strobe_n,
   input  wire logic       read_strobe_n,
   input  wire logic       write_guard_n,
   input  wire logic [7:0] io_in,
   output logic      [7:0] io_out,
   output logic            io_oe,
   output logic            busy_drive
);
   logic [7:0] last_byte;
   logic [1:0] last_kind, acnt, osel, rmode;
   logic [9:0] col;
   logic       fail, rbusy, prog_arm, ers_arm, ers_was, idx, rd_act;
   int         perr, sb_cnt;
   initial begin
      {io_out, io_oe, busy_drive, fail, rbusy, prog_arm, ers_arm, idx, rd_act} = '0;
      {last_byte, last_kind, acnt, osel, rmode, col} = '0;
      perr = 0;
      sb_cnt = 0;
   end
   task automatic go(input int ns, input logic r);
      fork
         begin
            busy_drive = 1'b1;
            rbusy = r;
            #(ns);
            busy_drive = 1'b0;
            rbusy = 1'b0;
         end
      join_none
   endtask
   // ------------------------------------------------------------
   // strobe capture and output
   // ------------------------------------------------------------
   always @(posedge write_strobe_n) begin
      if (!select_n) begin
         if (!read_strobe_n) perr++;
         last_byte = io_in;
         if (command_latch_strobe) begin
            last_kind = 2'h0;
            acnt = 2'h0;
            ers_was = ers_arm;
            ers_arm = 1'b0;
            if (busy_drive && io_in != 8'h70 && io_in != 8'hFF) perr++;
            if (io_in != 8'h10) prog_arm = 1'b0;
            case (io_in)
               8'h00, 8'h01, 8'h50: begin
                  rmode = (io_in == 8'h50) ? 2'h2 : io_in[1:0];
                  osel = 2'h0;
               end
               8'h70: osel = 2'h1;
               8'h90: begin
                  osel = 2'h2;
                  idx = 1'b0;
               end
               8'h80: prog_arm = 1'b1;
               8'h60: ers_arm = 1'b1;
               8'h10, 8'hD0: if (io_in == 8'h10 ? prog_arm : ers_was) begin
                  prog_arm = 1'b0;
                  fail = !write_guard_n;
                  if (write_guard_n) go(PROG_NS, 1'b0);
               end
               default: ;
            endcase
         end else if (address_latch_strobe) begin
            last_kind = 2'h1;
            if (acnt == 2'h0) col = (rmode == 2'h2) ? {6'h20, io_in[3:0]} : {1'b0, rmode[0], io_in};
            if (acnt == 2'h2 && io_in[7:6] != 2'h0) perr++;
            if (acnt == 2'h2 && !prog_arm && osel == 2'h0) go(READ_NS, 1'b1);
            acnt = (acnt == 2'h2) ? 2'h0 : acnt + 2'h1;
         end else last_kind = 2'h2;
      end
   end
   always @(negedge read_strobe_n) begin
      if (!select_n && write_strobe_n) begin
         io_oe = 1'b1;
         case (osel)
            2'h0: io_out = col[7:0] ^ {col[9:8], 6'h15};
            2'h1: io_out = {write_guard_n, !busy_drive, 5'h00, fail};
            default: io_out = idx ? ID_DEV : ID_MAKER;
         endcase
         if (osel == 2'h0 && col != 10'h20F) col = col + 10'h001;
         idx = 1'b1;
         rd_act = 1'b1;
      end
   end
   // held a cycle past the rise: the host samples through two flops
   always @(posedge read_strobe_n) io_oe <= #55 1'b0;
   always @(posedge select_n) begin
      if (rbusy) perr++;
      // only a deselect after output counts; the power-up rise is no standby entry
      if (!busy_drive && osel == 2'h0 && rd_act) sb_cnt++;
      rd_act = 1'b0;
   end
endmodule

// [verification/tb.sv]
/*
 tb: self-checking bench for the flash host controller and its flash model.
 assumes the flash model is compiled first; apb is driven from this module.
*/
`timescale 1ns/100ps
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, io_o, io_bus, held, fl_out;
   logic [31:0] pwdata, prdata, rd, sacc;
   logic        sel_n, cle, ale, we_n, re_n, wg_n, io_oe, fl_oe, fl_busy;
   int          miscompares, total_checks, n;
   // third address byte keeps its top lines low
   logic [9:0]  rows [15] = '{10'h000, 10'h001, 10'h050, 10'h090, 10'h070, 10'h0FF, 10'h060,
      10'h0D0, 10'h080, 10'h112, 10'h134, 10'h13F, 10'h2A5, 10'h25A, 10'h010};
   nfh_host uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_n(sel_n), .command_latch_strobe(cle),
      .address_latch_strobe(ale), .write_strobe_n(we_n), .read_strobe_n(re_n),
      .write_guard_n(wg_n), .io_port_o(io_o), .io_port_oe(io_oe), .io_port_i(io_bus),
      .ready_busy_n(~fl_busy));
   nfh_flash_model fl (.select_n(sel_n), .command_latch_strobe(cle),
      .address_latch_strobe(ale), .write_strobe_n(we_n), .read_strobe_n(re_n),
      .write_guard_n(wg_n), .io_in(io_bus), .io_out(fl_out), .io_oe(fl_oe),
      .busy_drive(fl_busy));
   // undriven port shows the inverse of its last value, never a stale copy
   always @* io_bus = io_oe ? io_o : fl_oe ? fl_out : ~held;
   always @(posedge pclk) if (io_oe || fl_oe) held <= io_bus;
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic finish_test();
      if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) chk(0, 1);
      if (k >= 20) finish_test();
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic poll(input int bit_no, output int k);
      k = 0;
      do begin
         apb(1'b0, nfh_pkg::REG_STATUS, 32'h0);
         sacc = sacc | rd;
         k++;
      end while (rd[bit_no] !== 1'b1 && k < 200);
      if (k >= 200) chk(0, 1);
      if (k >= 200) finish_test();
   endtask
   task automatic op(input logic [1:0] o, input logic [7:0] b, input logic e);
      int k;
      apb(1'b1, nfh_pkg::REG_CTRL, {16'h0000, b, 5'h00, e, o});
      poll(1, k);
   endtask
   task automatic rbyte(input logic e, input logic [7:0] exp);
      op(nfh_pkg::OP_READ, 8'h00, e);
      apb(1'b0, nfh_pkg::REG_RDATA, 32'h0);
      chk(rd[7:0], exp);
   endtask
   task automatic addr3(input logic [7:0] b0);
      op(nfh_pkg::OP_ADDR, b0, 1'b0);
      op(nfh_pkg::OP_ADDR, 8'h00, 1'b0);
      op(nfh_pkg::OP_ADDR, 8'hC0, 1'b0);
      chk(fl.last_byte, 8'h00);
   endtask
   // ------------------------------------------------------------
   // sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, held, sacc} = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (12) @(posedge pclk);
      chk({sel_n, wg_n, io_oe}, 3'b100);
      presetn <= 1'b1;
      apb(1'b0, nfh_pkg::REG_PINS, 32'h0);
      chk(rd, nfh_pkg::RST_PINS);
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1);
      apb(1'b0, nfh_pkg::REG_STATUS, 32'h0);
      chk(rd[1:0], 2'b11);
      foreach (rows[i]) begin
         op(rows[i][9:8], rows[i][7:0], 1'b0);
         chk({fl.last_kind, fl.last_byte}, rows[i]);
      end
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_STATUS, 1'b0);
      rbyte(1'b0, 8'h41);
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_READ_B, 1'b0);
      addr3(8'h07);
      poll(3, n);
      chk(n > 1, 1'b1);
      rbyte(1'b0, 8'h52);
      rbyte(1'b0, 8'h5D);
      addr3(8'h10);
      poll(3, n);
      rbyte(1'b1, 8'h45);
      chk(fl.sb_cnt, 1);
      apb(1'b1, nfh_pkg::REG_PINS, 32'h1);
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_SERIAL_IN, 1'b0);
      chk(wg_n, 1'b1);
      addr3(8'h00);
      op(nfh_pkg::OP_DATA, 8'h3C, 1'b0);
      sacc = '0;
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_READ_A, 1'b0);
      chk({sacc[5], fl.last_kind}, 3'b110);
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_PROGRAM, 1'b0);
      sacc = '0;
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_READ_A, 1'b0);
      chk({sacc[5], fl.last_byte}, 9'h110);
      op(nfh_pkg::OP_CMD, nfh_pkg::CMD_STATUS, 1'b0);
      rbyte(1'b1, 8'h80);
      chk(fl.sb_cnt, 1);
      poll(3, n);
      rbyte(1'b0, 8'hC0);
      // the page programmed above counts once, so the last pass is refused
      for (int j = 0; j < nfh_pkg::MAX_PROGRAMS; j++) begin
         op(nfh_pkg::OP_CMD, nfh_pkg::CMD_SERIAL_IN, 1'b0);
         addr3(8'h00);
         sacc = '0;
         op(nfh_pkg::OP_CMD, nfh_pkg::CMD_PROGRAM, 1'b0);
         chk(sacc[5], j == nfh_pkg::MAX_PROGRAMS - 1);
         poll(3, n);
      end
      chk(fl.perr, 0);
      finish_test();
   end
endmodule
